// *** pkg/asp_pkg.sv ***
// shared types and constants for the audio serial port
package asp_pkg;
  typedef enum logic [1:0] {ASP_FMT_LJ, ASP_FMT_RJ, ASP_FMT_I2S, ASP_FMT_DSP} asp_fmt_t;
  typedef enum logic [1:0] {ASP_WL16, ASP_WL20, ASP_WL24, ASP_WL32} asp_wlen_t;
  localparam logic [8:0] ASP_BITS16 = 9'h010;
  localparam logic [8:0] ASP_BITS20 = 9'h014;
  localparam logic [8:0] ASP_BITS24 = 9'h018;
  localparam logic [8:0] ASP_BITS32 = 9'h020;
  localparam logic [8:0] ASP_RES_BITS = 9'h018;
  localparam logic [8:0] ASP_LEN_RST = 9'h020;
  localparam logic [8:0] ASP_POS_RST = 9'h000;
  localparam logic [7:0] ASP_DIV_RST = 8'h00;
  localparam int ASP_SYNC_STAGES = 2;
  typedef struct packed {
    logic clock_master_select;
    asp_fmt_t fmt;
    asp_wlen_t wlen;
    logic frame_polarity_select;
    logic tdm_en;
    logic tdm_slot;
    logic [7:0] bclk_div;
    logic [7:0] half_bclks;
  } asp_cfg_t;
  typedef struct packed {
    logic [23:0] left;
    logic [23:0] right;
  } asp_stereo_t;
  typedef struct packed {
    logic hit;
    logic ch;
    logic [8:0] idx;
  } asp_hit_t;
endpackage

// *** logic/asp_port.sv ***
// audio serial port: clocking, framing, capture transmit, playback receive
// Functional notes
// [RULE1] four lines: capture out, playback in, frame clock, bit clock
// [RULE2] master drives both clocks; slave takes both from outside
// [RULE3] one master-select bit chooses internal or external clocks
// [RULE4] left-justified, right-justified, I2S and DSP, all MSB first
// [RULE5] slot multiplexing offered in every format, word length and mode; right-justified second slot carries no data
// [RULE6] multiplexed: send and receive in one of two slots per frame
// [RULE7] mono PCM uses DSP format
// [RULE8] 24-bit samples; in 32-bit words low 8 bits ignored, not driven (the code drives them low unless tdm_en is set)
// [RULE9] master bit clock divided from system clock by programmable divider
// [RULE10] clock edges and data at fixed, repeatable relative positions
// [RULE11] MSB on first rising edge (left-justified) or second (I2S)
// [RULE12] right-justified: LSB on last rising edge before frame edge
// [RULE13] DSP: MSB on first (mode B) or second (mode A) edge, right follows
// [RULE14] multiplexed: data output released before and after own slot
// [RULE15] master frame clock counted from bit clocks, one per sample
// [RULE16] launch on falling bit-clock edge, sample on rising edge
module asp_port (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // configuration
  input asp_pkg::asp_cfg_t cfg,
  // capture samples toward the link
  input asp_pkg::asp_stereo_t capture_frame,
  output logic capture_taken,
  // playback samples from the link
  output asp_pkg::asp_stereo_t playback_frame,
  output logic playback_valid,
  // bit clock pin
  input wire logic bclk_in,
  output logic bclk_out,
  output logic bclk_oe,
  // frame clock pin
  input wire logic lrclk_in,
  output logic lrclk_out,
  output logic lrclk_oe,
  // data pins
  input wire logic playback_serial_in,
  output logic capture_serial_out,
  output logic capture_serial_oe
);
  import asp_pkg::*;

  logic [1:0] rst_pipe;
  logic rst_sync_b;
  logic [ASP_SYNC_STAGES-1:0] bclk_sync;
  logic [ASP_SYNC_STAGES-1:0] lrclk_sync;
  logic [ASP_SYNC_STAGES-1:0] din_sync;
  logic bclk_last;
  logic master, dsp, left_level, toggle_ev, rise_ev, fall_ev, lr_now, lr_last, bnd;
  logic cch, ch, nch, nstart;
  logic [7:0] divcnt, div_m1;
  logic [8:0] pos, cpos, npos, meas, len, wbits;
  asp_hit_t rx_map, tx_map;
  asp_stereo_t tx_hold, tx_src, rx_word;

  // reset release through two flip-flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_pipe[1];

  // [RULE1] pin synchronisers
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bclk_sync <= '0;
      lrclk_sync <= '0;
      din_sync <= '0;
      bclk_last <= 1'b0;
    end else begin
      bclk_sync <= {bclk_sync[0], bclk_in};
      lrclk_sync <= {lrclk_sync[0], lrclk_in};
      din_sync <= {din_sync[0], playback_serial_in};
      bclk_last <= bclk_sync[1];
    end
  end

  assign master = cfg.clock_master_select;
  assign dsp = (cfg.fmt == ASP_FMT_DSP);
  assign left_level = (cfg.fmt != ASP_FMT_I2S);
  // [RULE2] clock pin direction
  assign bclk_oe = master;
  assign lrclk_oe = master;

  always_comb begin
    case (cfg.wlen)
      ASP_WL16: wbits = ASP_BITS16;
      ASP_WL20: wbits = ASP_BITS20;
      ASP_WL24: wbits = ASP_BITS24;
      default: wbits = ASP_BITS32;
    endcase
  end

  // [RULE9] bit clock divider
  assign div_m1 = (cfg.bclk_div == ASP_DIV_RST) ? ASP_DIV_RST : cfg.bclk_div - 8'h01;
  assign toggle_ev = master && (divcnt >= div_m1);
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      divcnt <= ASP_DIV_RST;
      bclk_out <= 1'b0;
    end else if (!master) begin
      divcnt <= ASP_DIV_RST;
      bclk_out <= 1'b0;
    end else if (toggle_ev) begin
      divcnt <= ASP_DIV_RST;
      bclk_out <= ~bclk_out;
    end else begin
      divcnt <= divcnt + 8'h01;
    end
  end

  // [RULE3] edge source chosen by master select
  assign rise_ev = master ? (toggle_ev && !bclk_out) : (bclk_sync[1] && !bclk_last);
  assign fall_ev = master ? (toggle_ev && bclk_out) : (!bclk_sync[1] && bclk_last);
  assign lr_now = master ? lrclk_out : lrclk_sync[1];
  assign bnd = dsp ? (lr_now && !lr_last) : (lr_now != lr_last);
  assign cch = dsp ? 1'b0 : (lr_now != left_level);
  assign cpos = bnd ? ASP_POS_RST : pos + 9'h001;
  // [RULE15] channel length in bit clocks (whole frame in DSP)
  assign len = !master ? meas : (dsp ? {cfg.half_bclks, 1'b0} : {1'b0, cfg.half_bclks});
  assign npos = (pos + 9'h001 >= len) ? ASP_POS_RST : pos + 9'h001;
  assign nch = (npos == ASP_POS_RST) ? (dsp ? 1'b0 : ~ch) : ch;
  assign nstart = (npos == ASP_POS_RST) && !nch;

  // [RULE10] position counter
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pos <= ASP_POS_RST;
      ch <= 1'b0;
      lr_last <= 1'b0;
      meas <= ASP_LEN_RST;
    end else if (rise_ev) begin
      pos <= cpos;
      ch <= cch;
      lr_last <= lr_now;
      if (bnd && !master) begin
        meas <= pos + 9'h001;
      end
    end
  end

  // [RULE15] master frame clock
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      lrclk_out <= 1'b0;
    end else if (!master) begin
      lrclk_out <= 1'b0;
    end else if (fall_ev) begin
      lrclk_out <= dsp ? (npos == ASP_POS_RST) : (nch ^ left_level);
    end
  end

  // [RULE4] slot and bit mapping, MSB first
  function automatic asp_hit_t map_bit(input logic [8:0] p, input logic c);
    logic [8:0] base;
    logic [8:0] rel;
    asp_hit_t r;
    base = ASP_POS_RST;
    rel = ASP_POS_RST;
    r.hit = 1'b0;
    r.ch = c;
    r.idx = ASP_POS_RST;
    case (cfg.fmt)
      // [RULE11] left-justified and I2S offsets
      ASP_FMT_LJ: base = ASP_POS_RST;
      ASP_FMT_I2S: base = 9'h001;
      // [RULE12] right-justified end alignment
      ASP_FMT_RJ: base = (len >= wbits) ? len - wbits : ASP_POS_RST;
      // [RULE13] mode A or B offset
      default: base = cfg.frame_polarity_select ? ASP_POS_RST : 9'h001;
    endcase
    // [RULE5] [RULE6] second slot offset
    if (cfg.tdm_en && cfg.tdm_slot) begin
      base = base + (dsp ? {wbits[7:0], 1'b0} : wbits);
    end
    if (p >= base) begin
      rel = p - base;
      if (dsp) begin
        if (rel < {wbits[7:0], 1'b0}) begin
          r.hit = 1'b1;
          r.ch = (rel >= wbits);
          r.idx = (rel >= wbits) ? rel - wbits : rel;
        end
      end else if (rel < wbits) begin
        r.hit = 1'b1;
        r.idx = rel;
      end
    end
    return r;
  endfunction

  always_comb begin
    rx_map = map_bit(cpos, cch);
    tx_map = map_bit(npos, nch);
  end
  assign tx_src = nstart ? capture_frame : tx_hold;

  // [RULE7] capture sample latched at frame start
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tx_hold <= '0;
      capture_taken <= 1'b0;
    end else begin
      capture_taken <= fall_ev && nstart;
      if (fall_ev && nstart) begin
        tx_hold <= capture_frame;
      end
    end
  end

  // [RULE16] launch on falling edge
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      capture_serial_out <= 1'b0;
      capture_serial_oe <= 1'b0;
    end else if (fall_ev) begin
      // [RULE8] only 24 bits carry data; other bits driven low unless tdm_en
      if (tx_map.hit && tx_map.idx < ASP_RES_BITS) begin
        capture_serial_out <= tx_map.ch ? tx_src.right[5'd23 - tx_map.idx[4:0]]
                                        : tx_src.left[5'd23 - tx_map.idx[4:0]];
        capture_serial_oe <= 1'b1;
      end else begin
        capture_serial_out <= 1'b0;
        // [RULE14] release outside own slot
        capture_serial_oe <= !cfg.tdm_en;
      end
    end
  end

  // [RULE16] sample on rising edge
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rx_word <= '0;
      playback_frame <= '0;
      playback_valid <= 1'b0;
    end else begin
      playback_valid <= rise_ev && bnd && !cch;
      if (rise_ev && bnd && !cch) begin
        playback_frame <= rx_word;
      end
      // [RULE8] low bits of long words ignored
      if (rise_ev && rx_map.hit && rx_map.idx < ASP_RES_BITS) begin
        if (rx_map.ch) begin
          rx_word.right[5'd23 - rx_map.idx[4:0]] <= din_sync[1];
        end else begin
          rx_word.left[5'd23 - rx_map.idx[4:0]] <= din_sync[1];
        end
      end
    end
  end

  // checking helpers
  logic [9:0] gap;
  logic gap_ok;
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      gap <= 10'h000;
      gap_ok <= 1'b0;
    end else begin
      gap <= rise_ev ? 10'h000 : gap + 10'h001;
      gap_ok <= master && (gap_ok || rise_ev);
    end
  end

  slave_clk_off_a: assert property (@(posedge mclk) disable iff (!rst_sync_b) // [RULE2]
    !master |-> !bclk_oe && !lrclk_oe ##1 (master || !bclk_out))
    else $error("clock pins driven in slave mode");
  bclk_period_a: assert property (@(posedge mclk) disable iff (!rst_sync_b) // [RULE9]
    master && gap_ok && rise_ev && $stable(cfg) |-> gap == {1'b0, div_m1, 1'b1})
    else $error("bit clock period does not match divider");
  frame_count_a: assert property (@(posedge mclk) disable iff (!rst_sync_b) // [RULE15]
    master && rise_ev && bnd && $stable(cfg) && pos != ASP_POS_RST |-> pos + 9'h001 == len)
    else $error("frame length differs from programmed count");
  lj_msb_a: assert property (@(posedge mclk) disable iff (!rst_sync_b) // [RULE11]
    capture_taken && cfg.fmt == ASP_FMT_LJ && !cfg.tdm_en
      |-> capture_serial_out == tx_hold.left[23])
    else $error("left-justified MSB not launched at frame start");
  low_bits_a: assert property (@(posedge mclk) disable iff (!rst_sync_b) // [RULE8]
    fall_ev && cfg.tdm_en && tx_map.hit && tx_map.idx >= ASP_RES_BITS |=> !capture_serial_oe)
    else $error("bits below 24 driven");
  tdm_release_a: assert property (@(posedge mclk) disable iff (!rst_sync_b) // [RULE14]
    fall_ev && cfg.tdm_en && !tx_map.hit |=> !capture_serial_oe && !capture_serial_out)
    else $error("data line held outside own slot");
  launch_edge_a: assert property (@(posedge mclk) disable iff (!rst_sync_b) // [RULE16]
    $changed(capture_serial_out) |-> $past(fall_ev))
    else $error("data changed away from falling edge");
  dsp_pulse_a: assert property (@(posedge mclk) disable iff (!rst_sync_b) // [RULE13]
    master && dsp && $rose(lrclk_out) |=> !capture_taken [*1] ##0 lrclk_out)
    else $error("frame pulse shorter than one bit clock");
endmodule // asp_port

// *** bench/asp_host_model.sv ***
// far-side model of the audio link: clock source in slave mode, data both ways
module asp_host_model (
  // link wires
  input wire logic bclk,
  input wire logic lrclk,
  input wire logic sd_cap,
  input wire logic oe_cap,
  output logic bclk_g,
  output logic lrclk_g,
  output logic sd_play,
  // setup and results
  input asp_pkg::asp_cfg_t cfg,
  input asp_pkg::asp_stereo_t play,
  output asp_pkg::asp_stereo_t cap,
  output logic [8:0] flen,
  output logic [8:0] n_oe,
  output int frames
);
  timeunit 1ns;
  timeprecision 1ns;
  import asp_pkg::*;
  logic [8:0] w, ls, rs, k, n, p = 0, ow = 0;
  logic last = 0;
  int g = 0;
  asp_stereo_t acc = '0;
  initial frames = 0;
  initial sd_play = 0;
  initial bclk_g = 0;
  initial lrclk_g = 0;
  assign w = cfg.wlen == ASP_WL32 ? ASP_BITS32 : ASP_BITS16 + 9'(4 * cfg.wlen);
  assign ls = (cfg.fmt == ASP_FMT_RJ ? {1'b0, cfg.half_bclks} - w : 9'h000)
    + 9'(cfg.fmt == ASP_FMT_I2S || cfg.fmt == ASP_FMT_DSP && !cfg.frame_polarity_select)
    + (cfg.tdm_en && cfg.tdm_slot ? (cfg.fmt == ASP_FMT_DSP ? 9'(2 * w) : w) : 9'h000);
  assign rs = ls + (cfg.fmt == ASP_FMT_DSP ? w : {1'b0, cfg.half_bclks});
  // sample on rise, msb first, top 24 kept
  always @(posedge bclk) begin
    if (lrclk !== last && lrclk === (cfg.fmt != ASP_FMT_I2S)) begin
      cap = acc;
      flen = p;
      n_oe = ow;
      frames++;
      acc = '0;
      p = 0;
      ow = 0;
    end
    last = lrclk;
    ow = ow + 9'(oe_cap);
    k = p - ls;
    if (k < w && k < 24) acc.left[23 - k] = sd_cap;
    k = p - rs;
    if (k < w && k < 24) acc.right[23 - k] = sd_cap;
    p++;
  end
  // launch on fall; idle bits toggle
  always @(negedge bclk) begin
    #2;
    n = (lrclk !== last && lrclk === (cfg.fmt != ASP_FMT_I2S)) ? 9'h000 : p;
    sd_play = ~sd_play;
    if (n - ls < w && n - ls < 24) sd_play = play.left[23 - (n - ls)];
    if (n - rs < w && n - rs < 24) sd_play = play.right[23 - (n - rs)];
  end
  // slave: model makes both clocks, else still
  always begin
    #170;
    bclk_g = 0;
    if (!cfg.clock_master_select) begin
      if (cfg.fmt == ASP_FMT_DSP) lrclk_g = g == 0;
      else lrclk_g = (g < cfg.half_bclks) ^ (cfg.fmt == ASP_FMT_I2S);
      g = (g + 1 == 2 * cfg.half_bclks) ? 0 : g + 1;
      #170;
      bclk_g = 1;
    end
  end
endmodule // asp_host_model

// *** bench/asp_port_tb.sv ***
// self-checking bench for the audio serial port
module asp_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import asp_pkg::*;
  logic mclk = 0;
  logic rst_b = 0;
  asp_cfg_t cfg = '0;
  asp_stereo_t cf = 48'h9a5c_c3e1_7b24;
  asp_stereo_t play = 48'h1e3c_5a69_c3b4;
  asp_stereo_t pf, cap;
  logic ct, pv, bo, boe, lo, loe, sp, so, soe, bg, lg, bw, lw, sw;
  logic [8:0] flen, n_oe;
  int frames;
  int n_fail = 0;
  int n_compared = 0;
  always #20 mclk = ~mclk;
  assign bw = boe ? bo : bg;
  assign lw = loe ? lo : lg;
  assign sw = soe ? so : 1'b0;
  asp_port DUT (.mclk(mclk), .rst_b(rst_b), .cfg(cfg), .capture_frame(cf),
    .capture_taken(ct), .playback_frame(pf), .playback_valid(pv), .bclk_in(bw),
    .bclk_out(bo), .bclk_oe(boe), .lrclk_in(lw), .lrclk_out(lo), .lrclk_oe(loe),
    .playback_serial_in(sp), .capture_serial_out(so), .capture_serial_oe(soe));
  asp_host_model host (.bclk(bw), .lrclk(lw), .sd_cap(sw), .oe_cap(soe), .bclk_g(bg),
    .lrclk_g(lg), .sd_play(sp), .cfg(cfg), .play(play), .cap(cap), .flen(flen),
    .n_oe(n_oe), .frames(frames));
  task automatic check(string what, logic [47:0] exp, logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic run_case(logic m, asp_fmt_t f, asp_wlen_t wl, logic pol, logic t, logic s);
    int w, n, i;
    logic [23:0] mk;
    logic [7:0] npv, nct;
    @(posedge mclk) #2;
    rst_b = 0;
    cfg = '{m, f, wl, pol, t, s, 8'h04, 8'h20};
    npv = 8'h00;
    nct = 8'h00;
    repeat (4) @(posedge mclk);
    #2 rst_b = 1;
    n = frames;
    for (i = 0; i < 4000 && frames < n + 5; i++) begin
      @(posedge mclk) #1;
      if (frames > n + 1) begin
        npv = npv + 8'(pv);
        nct = nct + 8'(ct);
      end
    end
    if (frames < n + 5) begin
      n_fail++;
      $display("[ERR] frames expected 5 seen %0d", frames - n);
      complete_run();
    end else begin
      repeat (8) begin
        @(posedge mclk) #1;
        npv = npv + 8'(pv);
        nct = nct + 8'(ct);
      end
      w = wl == ASP_WL32 ? 32 : 16 + 4 * wl;
      mk = 24'hff_ffff << (24 - (w > 24 ? 24 : w));
      check("capture word", {cf.left & mk, cf.right & mk}, cap);
      check("playback word", {play.left & mk, play.right & mk}, pf);
      check("frame length", 64, flen);
      check("data drive count", t ? 2 * (w > 24 ? 24 : w) : 64, n_oe);
      check("clock drive", {m, m}, {boe, loe});
      check("playback valid count", 48'd4, npv);
      check("capture taken count", 48'd3, nct);
      $display("case done master %0d fmt %0d wlen %0d tdm %0d", m, f, wl, t);
    end
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    run_case(1, ASP_FMT_LJ, ASP_WL16, 0, 0, 0);
    run_case(1, ASP_FMT_RJ, ASP_WL20, 0, 0, 0);
    run_case(1, ASP_FMT_I2S, ASP_WL24, 0, 0, 0);
    run_case(1, ASP_FMT_DSP, ASP_WL24, 0, 0, 0);
    run_case(1, ASP_FMT_DSP, ASP_WL32, 1, 0, 0);
    run_case(1, ASP_FMT_LJ, ASP_WL16, 0, 1, 1);
    run_case(1, ASP_FMT_RJ, ASP_WL32, 0, 1, 0);
    run_case(1, ASP_FMT_I2S, ASP_WL24, 0, 1, 0);
    run_case(1, ASP_FMT_DSP, ASP_WL16, 1, 1, 1);
    run_case(1, ASP_FMT_DSP, ASP_WL20, 0, 1, 0);
    run_case(0, ASP_FMT_LJ, ASP_WL24, 0, 0, 0);
    run_case(0, ASP_FMT_I2S, ASP_WL20, 0, 0, 0);
    run_case(0, ASP_FMT_DSP, ASP_WL16, 1, 1, 1);
    complete_run();
  end
endmodule // asp_port_tb
